//--- src/asr_pkg.sv
// shared constants, types and helpers for the converter serial readout block
package asr_pkg;

	localparam int RES_W = 16;
	localparam int CFG_W = 8;
	localparam int MODE_MSB = 7;
	localparam int MODE_LSB = 6;
	localparam int TIMER_W = 8;
	localparam logic [CFG_W-1:0] CFG_RESET = 8'h00;

	localparam logic [1:0] MODE_SEL_NOBUSY = 2'h0;
	localparam logic [1:0] MODE_SEL_BUSY = 2'h1;
	localparam logic [1:0] MODE_DC_NOBUSY = 2'h2;
	localparam logic [1:0] MODE_DC_BUSY = 2'h3;

	// level shown on the output pin as the busy indication
	localparam logic BUSY_LEVEL = 1'h0;

	localparam logic [4:0] BITS_FULL = 5'h10;
	localparam logic [3:0] CFG_BITS = 4'h8;

	// conversion length in ns, and in clk cycles at the core clock period
	localparam int CLK_PERIOD_NS = 10;
	localparam int CONV_TIME_NS = 2000;
	localparam int CONV_CYCLES = (CONV_TIME_NS / CLK_PERIOD_NS < 1) ? 1 :
		CONV_TIME_NS / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		ST_ACQ,
		ST_CONV,
		ST_CFG
	} asr_state_t;

	// link-domain capture handed to the core clock domain
	typedef struct packed {
		logic toggle;
		logic din;
	} asr_link_t;

	typedef struct packed {
		asr_state_t state;
		logic [TIMER_W-1:0] timer;
		logic cnv_s1;
		logic cnv_s2;
		logic cnv_s3;
		logic sclk_s1;
		logic sclk_s2;
		logic tog_s1;
		logic tog_s2;
		logic tog_s3;
		logic [RES_W-1:0] shreg;
		logic [4:0] bits_left;
		logic prefix;
		logic [1:0] mode;
		logic [CFG_W-1:0] cfg;
		logic [CFG_W-1:0] cfg_shift;
		logic [3:0] cfg_cnt;
		logic dout;
		logic oe;
		logic busy;
	} asr_core_t;

	localparam asr_core_t CORE_RESET = '{state: ST_ACQ, cnv_s1: 1'h1, cnv_s2: 1'h1,
		cnv_s3: 1'h1, cfg: CFG_RESET, default: '0};

	function automatic logic is_daisy(input logic [1:0] mode);
		return mode[1];
	endfunction : is_daisy

endpackage : asr_pkg

//--- src/asr_link_capture.sv
// serial-clock domain capture of the serial input, one toggle per falling edge
`timescale 1ns/10ps
`default_nettype none

module asr_link_capture (
	input wire logic serial_clk,
	input wire logic reset_n,
	input wire logic serial_data_in,
	output asr_pkg::asr_link_t link
);

	asr_pkg::asr_link_t q;
	asr_pkg::asr_link_t n;

	// the din bit is held a full serial period, long enough for the core to
	// see the toggle through its synchroniser and read it
	always_comb begin
		n = q;
		n.toggle = ~q.toggle;
		n.din = serial_data_in;
	end

	always_ff @(negedge serial_clk or negedge reset_n) begin
		if (!reset_n) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign link = q;

endmodule : asr_link_capture

`default_nettype wire

//--- src/asr_readout.sv
// conversion start, output modes and serial readout of the 16-bit converter
// Overview of operation
// - select modes: start pin rising ends acquisition, starts conversion, floats output.
// - a started conversion completes whatever the start pin does afterwards.
// - select no-busy: pin held low through conversion drives the msb at its end.
// - select no-busy: host pulls pin low after completion, msb then bits per fall.
// - select no-busy: output floats after the 16th fall or when the pin rises.
// - select busy: at completion output goes from float to low, then acquisition.
// - select busy: msb first on falls, floats after the 17th fall or pin high.
// - daisy no-busy: msb shown at completion, rest held in the shift register.
// - daisy: pin low, one bit out and one serial input bit in per fall after any busy bit.
// - daisy busy: busy indication shown at completion, result kept in shift register.
// - clock high at start pin fall enters config write of eight input bits.
// - config bits 7:6 choose one of the four output modes.
// - select modes: a short readout leaves unread bits that next time come out instead of the new result.
`timescale 1ns/10ps
`default_nettype none

module asr_readout (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic serial_clk,
	input wire logic convert_start_select,
	input wire logic serial_data_in,
	input wire logic [asr_pkg::RES_W-1:0] conversion_result,
	output logic serial_data_out,
	output logic serial_data_oe,
	output logic conversion_active
);

	asr_pkg::asr_core_t q;
	asr_pkg::asr_core_t n;
	asr_pkg::asr_link_t link;
	logic cnv_rise;
	logic cnv_fall;
	logic cnv_low;
	logic shift_ev;
	logic conv_done;

	asr_link_capture u_link (
		.serial_clk(serial_clk),
		.reset_n(reset_n),
		.serial_data_in(serial_data_in),
		.link(link)
	);

	// edges are taken from the second and third stages only
	assign cnv_rise = q.cnv_s2 & ~q.cnv_s3;
	assign cnv_fall = ~q.cnv_s2 & q.cnv_s3;
	assign cnv_low = ~q.cnv_s2 & ~q.cnv_s3;
	assign shift_ev = q.tog_s2 ^ q.tog_s3;
	assign conv_done = (q.state == asr_pkg::ST_CONV) && (q.timer == '0);

	always_comb begin
		n = q;
		n.cnv_s1 = convert_start_select;
		n.cnv_s2 = q.cnv_s1;
		n.cnv_s3 = q.cnv_s2;
		n.sclk_s1 = serial_clk;
		n.sclk_s2 = q.sclk_s1;
		n.tog_s1 = link.toggle;
		n.tog_s2 = q.tog_s1;
		n.tog_s3 = q.tog_s2;
		unique case (q.state)
			asr_pkg::ST_ACQ: begin
				if (cnv_rise) begin
					n.state = asr_pkg::ST_CONV;
					n.timer = asr_pkg::TIMER_W'(asr_pkg::CONV_CYCLES - 1);
					n.mode = q.cfg[asr_pkg::MODE_MSB:asr_pkg::MODE_LSB];
					n.busy = 1'h1;
				end else if (cnv_fall && q.sclk_s2) begin
					n.state = asr_pkg::ST_CFG;
					n.cfg_cnt = '0;
				end else if (shift_ev && !q.cnv_s2) begin
					// busy bit goes out on the first fall without moving the data
					if (q.prefix) begin
						n.prefix = 1'h0;
					end else begin
						n.shreg = {q.shreg[asr_pkg::RES_W-2:0],
							asr_pkg::is_daisy(q.mode) & link.din};
						if (q.bits_left != '0) begin
							n.bits_left = q.bits_left - 5'h01;
						end
					end
				end
			end
			asr_pkg::ST_CONV: begin
				// the start pin is not looked at until the timer expires
				if (q.timer == '0) begin
					n.state = asr_pkg::ST_ACQ;
					n.busy = 1'h0;
					n.prefix = q.mode[0];
					// in select modes unread bits of a short readout win over the new result
					if (asr_pkg::is_daisy(q.mode) || q.bits_left == '0) begin
						n.shreg = conversion_result;
						n.bits_left = asr_pkg::BITS_FULL;
					end
				end else begin
					n.timer = q.timer - asr_pkg::TIMER_W'(1);
				end
			end
			asr_pkg::ST_CFG: begin
				if (cnv_rise) begin
					n.state = asr_pkg::ST_ACQ;
					if (q.cfg_cnt == asr_pkg::CFG_BITS) begin
						n.cfg = q.cfg_shift;
					end
				end else if (shift_ev) begin
					n.cfg_shift = {q.cfg_shift[asr_pkg::CFG_W-2:0], link.din};
					if (q.cfg_cnt != asr_pkg::CFG_BITS) begin
						n.cfg_cnt = q.cfg_cnt + 4'h1;
					end
				end
			end
		endcase
		// pin drive is worked out from the next state so it leaves a flip-flop
		if (n.state == asr_pkg::ST_CFG) begin
			n.oe = asr_pkg::is_daisy(n.mode);
			n.dout = n.cfg_shift[asr_pkg::CFG_W-1];
		end else if (n.state == asr_pkg::ST_CONV && n.mode == asr_pkg::MODE_DC_BUSY) begin
			n.oe = 1'h1;
			n.dout = ~asr_pkg::BUSY_LEVEL;
		end else begin
			n.dout = n.prefix ? asr_pkg::BUSY_LEVEL : n.shreg[asr_pkg::RES_W-1];
			n.oe = asr_pkg::is_daisy(n.mode) | ((n.state == asr_pkg::ST_ACQ) && !q.cnv_s2 &&
				((n.bits_left != '0) || n.prefix));
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			q <= asr_pkg::CORE_RESET;
		end else begin
			q <= n;
		end
	end

	assign serial_data_out = q.dout;
	assign serial_data_oe = q.oe;
	assign conversion_active = q.busy;

	localparam int CONV_LEN_M1 = asr_pkg::CONV_CYCLES - 1;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	property p_conv_float;
		(q.state == asr_pkg::ST_CONV && q.timer != '0 && !q.mode[1]) |=> !serial_data_oe;
	endproperty
	a_conv_float: assert property (p_conv_float) else $error("output driven in conversion");

	property p_conv_len;
		$rose(conversion_active) |-> ##CONV_LEN_M1 conversion_active ##1 !conversion_active;
	endproperty
	a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

	property p_conv_hold;
		$rose(conversion_active) |-> (q.state == asr_pkg::ST_CONV)[*8];
	endproperty
	a_conv_hold: assert property (p_conv_hold) else $error("conversion cut short");

	property p_msb_at_end;
		(conv_done && q.mode == asr_pkg::MODE_SEL_NOBUSY && !q.cnv_s2 && q.bits_left == '0)
			|=> serial_data_oe && serial_data_out == $past(conversion_result[asr_pkg::RES_W-1]);
	endproperty
	a_msb_at_end: assert property (p_msb_at_end) else $error("msb missing at end");

	property p_float_16;
		(q.state == asr_pkg::ST_ACQ && q.mode == asr_pkg::MODE_SEL_NOBUSY && cnv_low &&
			shift_ev && !q.prefix && q.bits_left == 5'h01) |=> !serial_data_oe;
	endproperty
	a_float_16: assert property (p_float_16) else $error("no float after last bit");

	property p_float_pin_high;
		(q.state == asr_pkg::ST_ACQ && q.cnv_s2 && q.cnv_s3 && !q.mode[1]) |=> !serial_data_oe;
	endproperty
	a_float_pin_high: assert property (p_float_pin_high) else $error("drive with pin high");

	property p_busy_low;
		(conv_done && q.mode == asr_pkg::MODE_SEL_BUSY && !q.cnv_s2)
			|=> serial_data_oe && serial_data_out == asr_pkg::BUSY_LEVEL;
	endproperty
	a_busy_low: assert property (p_busy_low) else $error("busy level missing");

	property p_busy_then_msb;
		(q.state == asr_pkg::ST_ACQ && q.mode == asr_pkg::MODE_SEL_BUSY && cnv_low &&
			shift_ev && q.prefix) |=> serial_data_oe && !q.prefix &&
			serial_data_out == $past(q.shreg[asr_pkg::RES_W-1]);
	endproperty
	a_busy_then_msb: assert property (p_busy_then_msb) else $error("msb not after busy");

	property p_daisy_msb;
		(conv_done && q.mode == asr_pkg::MODE_DC_NOBUSY)
			|=> serial_data_oe && serial_data_out == $past(conversion_result[asr_pkg::RES_W-1]);
	endproperty
	a_daisy_msb: assert property (p_daisy_msb) else $error("daisy msb missing");

	property p_daisy_shift;
		(q.state == asr_pkg::ST_ACQ && q.mode[1] && cnv_low && shift_ev && !q.prefix)
			|=> q.shreg == {$past(q.shreg[asr_pkg::RES_W-2:0]), $past(link.din)};
	endproperty
	a_daisy_shift: assert property (p_daisy_shift) else $error("daisy shift wrong");

	property p_daisy_busy;
		(conv_done && q.mode == asr_pkg::MODE_DC_BUSY) |=> serial_data_oe &&
			serial_data_out == asr_pkg::BUSY_LEVEL && q.shreg == $past(conversion_result);
	endproperty
	a_daisy_busy: assert property (p_daisy_busy) else $error("daisy busy wrong");

	property p_cfg_enter;
		(q.state == asr_pkg::ST_ACQ && cnv_fall && q.sclk_s2) |=> q.state == asr_pkg::ST_CFG;
	endproperty
	a_cfg_enter: assert property (p_cfg_enter) else $error("config write not entered");

	property p_leftover;
		(conv_done && !q.mode[1] && q.bits_left != '0) |=> q.shreg == $past(q.shreg);
	endproperty
	a_leftover: assert property (p_leftover) else $error("leftover bits lost");

	property p_start_conv;
		(q.state == asr_pkg::ST_ACQ && cnv_rise) |=> q.state == asr_pkg::ST_CONV &&
			conversion_active && q.timer == asr_pkg::TIMER_W'(CONV_LEN_M1);
	endproperty
	a_start_conv: assert property (p_start_conv) else $error("start not taken");

	property p_conv_keep;
		(q.state == asr_pkg::ST_CONV && q.timer != '0) |=> q.state == asr_pkg::ST_CONV;
	endproperty
	a_conv_keep: assert property (p_conv_keep) else $error("conversion left early");

	property p_mode_latch;
		(q.state == asr_pkg::ST_ACQ && cnv_rise)
			|=> q.mode == $past(q.cfg[asr_pkg::MODE_MSB:asr_pkg::MODE_LSB]);
	endproperty
	a_mode_latch: assert property (p_mode_latch) else $error("mode not latched");

	property p_float_17;
		(q.state == asr_pkg::ST_ACQ && q.mode == asr_pkg::MODE_SEL_BUSY && cnv_low &&
			shift_ev && !q.prefix && q.bits_left == 5'h01) |=> !serial_data_oe;
	endproperty
	a_float_17: assert property (p_float_17) else $error("no float after busy readout");

	property p_busy_conv;
		(q.state == asr_pkg::ST_CONV && q.timer != '0 && q.mode == asr_pkg::MODE_DC_BUSY)
			|=> serial_data_oe && serial_data_out == ~asr_pkg::BUSY_LEVEL;
	endproperty
	a_busy_conv: assert property (p_busy_conv) else $error("busy not shown");

	property p_skip_busy;
		(q.state == asr_pkg::ST_ACQ && q.mode == asr_pkg::MODE_DC_BUSY && cnv_low &&
			shift_ev && q.prefix) |=> !q.prefix && q.shreg == $past(q.shreg) &&
			serial_data_out == $past(q.shreg[asr_pkg::RES_W-1]);
	endproperty
	a_skip_busy: assert property (p_skip_busy) else $error("busy bit not consumed alone");

	property p_pin_high_hold;
		(q.state == asr_pkg::ST_ACQ && q.cnv_s2 && q.cnv_s3)
			|=> q.shreg == $past(q.shreg) && q.bits_left == $past(q.bits_left);
	endproperty
	a_pin_high_hold: assert property (p_pin_high_hold) else $error("shift with pin high");

	property p_cfg_load;
		(q.state == asr_pkg::ST_CFG && cnv_rise && q.cfg_cnt == asr_pkg::CFG_BITS)
			|=> q.state == asr_pkg::ST_ACQ && q.cfg == $past(q.cfg_shift);
	endproperty
	a_cfg_load: assert property (p_cfg_load) else $error("config not loaded");

	property p_cfg_shift;
		(q.state == asr_pkg::ST_CFG && !cnv_rise && shift_ev)
			|=> q.cfg_shift == {$past(q.cfg_shift[asr_pkg::CFG_W-2:0]), $past(link.din)};
	endproperty
	a_cfg_shift: assert property (p_cfg_shift) else $error("config shift wrong");

	property p_done_acq;
		conv_done |=> q.state == asr_pkg::ST_ACQ && !conversion_active;
	endproperty
	a_done_acq: assert property (p_done_acq) else $error("no return to acquisition");

	property p_load_result;
		(conv_done && (q.mode[1] || q.bits_left == '0))
			|=> q.shreg == $past(conversion_result) && q.bits_left == asr_pkg::BITS_FULL;
	endproperty
	a_load_result: assert property (p_load_result) else $error("result not loaded");

	property p_cv_sel;
		conv_done && q.mode == asr_pkg::MODE_SEL_NOBUSY;
	endproperty
	c_cv_sel: cover property (p_cv_sel);

	property p_cv_sel_busy;
		conv_done && q.mode == asr_pkg::MODE_SEL_BUSY;
	endproperty
	c_cv_sel_busy: cover property (p_cv_sel_busy);

	property p_cv_daisy;
		conv_done && q.mode == asr_pkg::MODE_DC_NOBUSY;
	endproperty
	c_cv_daisy: cover property (p_cv_daisy);

	property p_cv_daisy_busy;
		conv_done && q.mode == asr_pkg::MODE_DC_BUSY;
	endproperty
	c_cv_daisy_busy: cover property (p_cv_daisy_busy);

	property p_cv_cfg;
		q.state == asr_pkg::ST_CFG && cnv_rise && q.cfg_cnt == asr_pkg::CFG_BITS;
	endproperty
	c_cv_cfg: cover property (p_cv_cfg);

endmodule : asr_readout

`default_nettype wire

//--- verification/asr_host.sv
// host model: start pin, serial clock and serial data for the readout block
`timescale 1ns/10ps
`default_nettype none

module asr_host (
	output logic serial_clk,
	output logic convert_start_select,
	output logic serial_data_in,
	input wire logic line
);
	initial begin
		serial_clk = 1'h0; // idle low so a pin fall never opens config
		convert_start_select = 1'h1;
		serial_data_in = 1'h0;
	end
	// each device has its own start line; low selects it
	task automatic set_pin(input logic v);
		convert_start_select <= v;
	endtask : set_pin
	// one bit: sample just before the fall, since the output lags a fall by up to 30 ns
	task automatic bit_cyc(input logic d, output logic q);
		serial_data_in = d;
		serial_clk = 1'h1;
		#31;
		q = line;
		#1;
		serial_clk = 1'h0;
		#32;
	endtask : bit_cyc
	// clock high at the pin fall, then eight falls, pin rise ends it
	task automatic cfg(input logic [7:0] v);
		serial_clk = 1'h1;
		#64 convert_start_select = 1'h0;
		#64;
		for (int i = 7; i >= 0; i--) begin
			serial_data_in = v[i];
			#32 serial_clk = 1'h0;
			#32 serial_clk = 1'h1;
		end
		#64 convert_start_select = 1'h1;
		#64 serial_clk = 1'h0;
	endtask : cfg
endmodule : asr_host

`default_nettype wire

//--- verification/asr_readout_test.sv
// self-checking bench for the converter readout block
`timescale 1ns/10ps
`default_nettype none

module asr_readout_test;
	logic clk;
	logic reset_n;
	logic [asr_pkg::RES_W-1:0] res;
	logic [1:0] mode;
	logic [15:0] lf;
	logic q;
	wire logic sclk;
	wire logic start;
	wire logic sdi;
	wire logic sdo;
	wire logic oe;
	wire logic busy;
	wire logic line;
	int mismatches;
	int tests_run;
	int cycles;
	int n;
	logic exp_q[$];

	// pull-up on the released output line
	assign line = oe ? sdo : 1'h1;

	asr_readout u_dut (.clk(clk), .reset_n(reset_n), .serial_clk(sclk),
		.convert_start_select(start), .serial_data_in(sdi),
		.conversion_result(res), .serial_data_out(sdo), .serial_data_oe(oe),
		.conversion_active(busy));
	asr_host u_host (.serial_clk(sclk), .convert_start_select(start),
		.serial_data_in(sdi), .line(line));

	function automatic logic [15:0] nxt(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction : nxt

	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s exp %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic stop_test();
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : stop_test

	task automatic do_reset();
		@(posedge clk);
		reset_n <= 1'h0;
		repeat (2) @(posedge clk);
		reset_n <= 1'h1;
		repeat (4) @(posedge clk);
		exp_q = {};
	endtask : do_reset

	// start a conversion; hold keeps the pin low through it
	task automatic conv(input logic hold);
		@(posedge clk);
		lf = nxt(lf);
		res <= lf;
		u_host.set_pin(1'h0);
		#100;
		u_host.set_pin(1'h1);
		n = 0;
		while (busy !== 1'h1 && n < 20) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (!mode[1]) chk("float", 16'(oe), 16'h0000);
		if (hold) u_host.set_pin(1'h0);
		n = 1;
		while (n < 1000) begin
			@(posedge clk);
			#1;
			if (busy !== 1'h1) break;
			n++;
		end
		chk("conv_len", 16'(n), 16'(asr_pkg::CONV_CYCLES));
		// select modes keep unread bits and drop the new result
		if (mode[1] || exp_q.size() == 0) begin
			exp_q = {};
			if (mode[0]) exp_q.push_back(asr_pkg::BUSY_LEVEL);
			for (int b = 15; b >= 0; b--) exp_q.push_back(res[b]);
		end
		repeat (4) @(posedge clk);
		u_host.set_pin(1'h0);
		#50;
		chk("first_bit", 16'(line), 16'(exp_q[0]));
	endtask : conv

	task automatic rd(input int cnt);
		logic d;
		for (int i = 0; i < cnt; i++) begin
			lf = nxt(lf);
			d = lf[0];
			u_host.bit_cyc(d, q);
			chk("bit", 16'(q), 16'(exp_q.pop_front()));
			if (mode[1] && !(mode[0] && i == 0)) exp_q.push_back(d);
		end
		repeat (6) @(posedge clk);
	endtask : rd

	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end

	// hang guard, well above the few thousand cycles the run needs
	always @(posedge clk) begin
		cycles++;
		if (cycles == 30000) begin
			mismatches++;
			stop_test();
		end
	end

	initial begin
		// non-blocking so every flop is already waiting when reset falls at time zero
		reset_n <= 1'h0;
		res = '0;
		lf = 16'h0027;
		mode = 2'h0;
		repeat (2) @(posedge clk);
		reset_n <= 1'h1;
		repeat (4) @(posedge clk);
		conv(1'h0);
		rd(16);
		chk("release16", 16'(oe), 16'h0000);
		$display("test select done");
		conv(1'h1);
		rd(10);
		conv(1'h1);
		rd(6);
		conv(1'h1);
		rd(16);
		$display("test leftover done");
		for (int m = 1; m < 4; m++) begin
			u_host.set_pin(1'h1);
			do_reset();
			mode = 2'(m);
			u_host.cfg({mode, 6'h00});
			conv(1'h1);
			rd(m == 1 ? 17 : 30 + m);
			chk("release", 16'(oe), 16'(mode[1]));
			$display("test mode %0d done", m);
		end
		stop_test();
	end
endmodule : asr_readout_test

`default_nettype wire
